// [hw/sleep_ctl_defines.svh]
// Purpose: constants for the sleep-mode control block
// Assumes: 100 MHz clock
// Notes: cycle figures are counted on rising clock edges
`ifndef SLEEP_CTL_DEFINES_SVH
`define SLEEP_CTL_DEFINES_SVH
`define SLEEP_ENTRY_CYCLES 2
`define SLEEP_EXIT_CYCLES 2
`define SLEEP_SETTLE_CYCLES 2
`define SLEEP_CNT_W 2
`endif

// [hw/sleep_ctl_pkg.sv]
// Purpose: types for the sleep-mode control block
// Assumes: nothing
// Notes: constants live in the defines header
package sleep_ctl_pkg;
   typedef enum logic [1:0] {st_awake, st_entering, st_asleep, st_waking} sleep_state_e;
   typedef enum logic [1:0] {op_none, op_read, op_write} bus_op_e;
endpackage

// [hw/sleep_sync.sv]
// Purpose: two-flop synchroniser for the asynchronous sleep request
// Assumes: single clock domain on the output side
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
module sleep_sync (
   // clock, reset and enable
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // level in and out
   input wire logic async_in,
   output logic sync_out
);
   typedef struct packed {
      logic meta;
      logic sync;
   } sync_s;
   sync_s s_q;
   sync_s s_d;

   // next stage values
   always_comb begin
      s_d = s_q;
      s_d.meta = async_in;
      s_d.sync = s_q.meta;
   end

   // registered stages, frozen while the enable is low
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_q <= '0;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign sync_out = s_q.sync;
endmodule

// [hw/sleep_ctl.sv]
// Purpose: sleep entry/exit and cycle qualification of a pipelined burst SRAM
// Assumes: host keeps its own obligations; inputs other than the sleep request synchronous to clk
// Notes: sleep request is synchronised, then entry/exit counted on clk
//        bus decode runs only while awake; data drive enable is registered
//        burst continue after a deselect raises neither burst_continue nor deselect
// Functional notes
// RL1 - sleep request asynchronous, active high
// RL2 - asleep means deselected, no array access
// RL3 - sleep lasts while request held high
// RL4 - asleep ignores inputs, outputs high-Z
// RL5 - stop honouring inputs within two cycles
// RL6 - resume sampling two cycles after fall
// RL7 - full low power within two cycles
// RL8 - pending access not guaranteed on entry
// RL9 - host finishes accesses before raising request
// RL10 - host issues deselect/read while waking
// RL11 - host gives valid selects when advance low
// RL12 - write on we low, read on high
// RL13 - result also gated by sleep, output enable
// RL14 - continue-deselect only after a deselect
// RL15 - delays counted on clk after synchronising
`timescale 1ns/100ps
`include "sleep_ctl_defines.svh"
module sleep_ctl #(
   parameter int ENTRY_CYCLES = `SLEEP_ENTRY_CYCLES,
   parameter int EXIT_CYCLES = `SLEEP_EXIT_CYCLES
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // sleep and output control
   input wire logic sleep_request,
   input wire logic output_enable_n,
   // bus cycle inputs
   input wire logic chip_select1_n,
   input wire logic chip_select2,
   input wire logic chip_select3_n,
   input wire logic address_advance,
   input wire logic write_enable_n,
   // cycle qualification
   output logic read_start,
   output logic write_start,
   output logic burst_continue,
   output logic deselect,
   output logic selected,
   // power and output state
   output logic in_sleep,
   output logic inputs_enabled,
   output logic data_out_en,
   output logic sleep_state_entered
);
   localparam logic [`SLEEP_CNT_W-1:0] ENTRY_LAST = (`SLEEP_CNT_W)'(ENTRY_CYCLES - 1);
   localparam logic [`SLEEP_CNT_W-1:0] EXIT_LAST = (`SLEEP_CNT_W)'(EXIT_CYCLES - 1);

   // latency budget, counted in enabled clock edges:
   // two edges go to the synchroniser before the state machine sees a change,
   // then ENTRY_CYCLES edges of entering before full sleep is reported,
   // or EXIT_CYCLES edges of waking before inputs are honoured again;
   // a host that needs a bound from the pin must add the synchroniser edges
   // limitation: a request pulse shorter than one enabled edge may be missed

   typedef struct packed {
      // sequencing
      sleep_ctl_pkg::sleep_state_e st;
      logic [`SLEEP_CNT_W-1:0] cnt;
      // one-cycle cycle-start pulses
      logic read_start;
      logic write_start;
      logic burst_continue;
      logic deselect;
      // pipeline memory of the last new cycle
      logic selected;
      logic read_pipe;
      // power and output status
      logic in_sleep;
      logic inputs_enabled;
      logic data_out_en;
      logic entered;
   } ctl_s;
   ctl_s s_q;
   ctl_s s_d;
   // entry and exit are counted from this synchronised level
   logic req_sync;

   // chip selects qualify a new cycle only when all three agree
   // active levels: first and third low, second high
   function automatic logic sel_ok(input logic cs1_n, input logic cs2, input logic cs3_n);
      sel_ok = !cs1_n && cs2 && !cs3_n;
   endfunction

   // RL1 RL15 synchronise request
   // two flops; nothing but the second stage is read
   sleep_sync u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .async_in(sleep_request),
      .sync_out(req_sync)
   );

   // sleep sequencing and cycle decode
   always_comb begin
      logic honour;
      logic sel;
      honour = 1'b0;
      sel = 1'b0;
      s_d = s_q;
      s_d.read_start = 1'b0;
      s_d.write_start = 1'b0;
      s_d.burst_continue = 1'b0;
      s_d.deselect = 1'b0;
      // state walk: awake -> entering -> asleep -> waking -> awake;
      // a request change during entering or waking turns the walk around,
      // so a short low pulse never lets the bus in half awake
      case (s_q.st)
         sleep_ctl_pkg::st_awake: begin
            honour = 1'b1;
            // RL5 RL7 start entry count
            if (req_sync) begin
               s_d.st = sleep_ctl_pkg::st_entering;
               s_d.cnt = '0;
            end
         end
         sleep_ctl_pkg::st_entering: begin
            // synchroniser latency already consumes the entry budget
            honour = 1'b0;
            // a falling request aborts entry into waking
            if (!req_sync) begin
               s_d.st = sleep_ctl_pkg::st_waking;
               s_d.cnt = '0;
            end else if (s_q.cnt >= ENTRY_LAST) begin
               s_d.st = sleep_ctl_pkg::st_asleep;
            end else begin
               s_d.cnt = s_q.cnt + 1'b1;
            end
         end
         sleep_ctl_pkg::st_asleep: begin
            // RL3 hold while high
            // RL2 deselected: nothing decoded here
            if (!req_sync) begin
               s_d.st = sleep_ctl_pkg::st_waking;
               s_d.cnt = '0;
            end
         end
         sleep_ctl_pkg::st_waking: begin
            // RL6 resume after count
            // a new rise restarts entry from the beginning
            if (req_sync) begin
               s_d.st = sleep_ctl_pkg::st_entering;
               s_d.cnt = '0;
            end else if (s_q.cnt >= EXIT_LAST) begin
               s_d.st = sleep_ctl_pkg::st_awake;
            end else begin
               s_d.cnt = s_q.cnt + 1'b1;
            end
         end
         // unreachable codes fall back to awake
         default: begin
            s_d.st = sleep_ctl_pkg::st_awake;
            s_d.cnt = '0;
         end
      endcase

      // RL4 RL2 ignore inputs asleep
      if (honour) begin
         sel = sel_ok(chip_select1_n, chip_select2, chip_select3_n);
         if (!address_advance) begin
            // RL12 start read or write
            s_d.read_start = sel && write_enable_n;
            s_d.write_start = sel && !write_enable_n;
            s_d.deselect = !sel;
            s_d.selected = sel;
            s_d.read_pipe = sel && write_enable_n;
         end else begin
            // burst continues the previous cycle; after a deselect this is continue-deselect
            s_d.burst_continue = s_q.selected;
         end
      end else begin
         // RL8 pending access dropped
         s_d.selected = 1'b0;
         s_d.read_pipe = 1'b0;
      end

      // RL13 final gating, registered with the pipe
      // drive needs a read in the pipe, output enable low and no request
      // the output enable is sampled, so its effect lags one clock
      s_d.in_sleep = (s_d.st == sleep_ctl_pkg::st_asleep);
      s_d.entered = s_d.in_sleep && !s_q.in_sleep;
      s_d.inputs_enabled = (s_d.st == sleep_ctl_pkg::st_awake);
      s_d.data_out_en = s_d.read_pipe && !output_enable_n && !req_sync &&
                        (s_d.st == sleep_ctl_pkg::st_awake);
   end

   // state register; clock enable freezes everything
   // reset leaves the block awake with inputs honoured, as after power-up
   // with the request low
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_q <= '{st: sleep_ctl_pkg::st_awake, inputs_enabled: 1'b1, default: '0};
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // outputs straight from flops
   // cycle-start pulses, one cycle each
   assign read_start = s_q.read_start;
   assign write_start = s_q.write_start;
   assign burst_continue = s_q.burst_continue;
   assign deselect = s_q.deselect;

   // level held between cycles
   assign selected = s_q.selected;

   // power status
   assign in_sleep = s_q.in_sleep;
   assign inputs_enabled = s_q.inputs_enabled;

   // output drive and entry mark
   assign data_out_en = s_q.data_out_en;
   assign sleep_state_entered = s_q.entered;
endmodule

// [testbench/sleep_ctl_assertions.sv]
// Purpose: checker for sleep entry, exit and cycle starts
// Assumes: one clock, request held long
// Notes: bounds allow for the synchroniser
`timescale 1ns/100ps
module sleep_ctl_assertions #(parameter int ENTRY_CYCLES = 2, EXIT_CYCLES = 2) (
   // block inputs
   input wire logic clk, reset_n, clk_en, sleep_request, write_enable_n,
   input wire logic chip_select1_n, chip_select2, chip_select3_n, address_advance,
   // block outputs
   input wire logic read_start, write_start, in_sleep, inputs_enabled, sleep_state_entered
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // new cycle with valid selects, request held or released with clock running
   wire go = !chip_select1_n && chip_select2 && !chip_select3_n && !address_advance;
   wire hi = sleep_request && clk_en;
   wire lo = !sleep_request && clk_en;
   property p_quiet; in_sleep |-> !inputs_enabled ##1 !read_start && !write_start; endproperty
   a_quiet: assert property (p_quiet) else $error("busy asleep");
   property p_stop; hi [*5] |=> !inputs_enabled; endproperty
   a_stop: assert property (p_stop) else $error("inputs kept");
   property p_full; hi [*8] |=> in_sleep; endproperty
   a_full: assert property (p_full) else $error("no sleep");
   property p_stay; lo [*6] |=> !in_sleep; endproperty
   a_stay: assert property (p_stay) else $error("sleep kept");
   property p_wake; lo [*7] |=> inputs_enabled; endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   property p_early; $rose(inputs_enabled) && $past(clk_en) && $past(clk_en, 2)
      |-> !$past(sleep_request, 2); endproperty
   a_early: assert property (p_early) else $error("early wake");
   property p_mark; $rose(in_sleep) |-> sleep_state_entered; endproperty
   a_mark: assert property (p_mark) else $error("no entry mark");
   property p_go; clk_en && inputs_enabled && go ##1 inputs_enabled
      |-> read_start == $past(write_enable_n) && write_start != $past(write_enable_n); endproperty
   a_go: assert property (p_go) else $error("bad start");
   c_sleep: cover property ($rose(in_sleep));
   c_wake: cover property ($rose(inputs_enabled));
   c_write: cover property (write_start);
endmodule

// [testbench/host_model.sv]
// Purpose: host controller model for the sram bus
// Assumes: op 0 deselect, 1 read, 2 write, 3 continue
// Notes: writes during wake-up are turned into reads
`timescale 1ns/100ps
module host_model (
   // clock, reset and bench requests
   input wire logic clk, reset_n, sleep_want,
   input wire logic [1:0] op,
   // bus pins
   output logic chip_select1_n, chip_select2, chip_select3_n,
   output logic address_advance, write_enable_n, sleep_request
);
   logic [1:0] o, last_q;
   logic [2:0] wake_q;
   // only reads, deselects or continues while waking
   always_comb o = (op == 2'h2 && wake_q != 3'h0) ? 2'h1 : op;
   // valid selects on new cycles, continue after any cycle
   assign chip_select1_n = o == 2'h0;
   assign chip_select2 = 1'b1;
   assign chip_select3_n = 1'b0;
   assign address_advance = o == 2'h3;
   assign write_enable_n = o != 2'h2;
   // request only after two idle cycles
   always_ff @(posedge clk) begin
      last_q <= reset_n ? o : 2'h0;
      if (!reset_n) wake_q <= 3'h0;
      else if (wake_q != 3'h0) wake_q <= wake_q - 3'h1;
      if (!reset_n) sleep_request <= 1'b0;
      else if (sleep_want && o == 2'h0 && last_q == 2'h0) sleep_request <= 1'b1;
      else if (!sleep_want && sleep_request) begin
         sleep_request <= 1'b0;
         wake_q <= 3'h7;
      end
   end
endmodule

// [testbench/tb_top.sv]
// Purpose: self-checking bench for the sleep control block
// Assumes: host model keeps the bus legal
// Notes: pulses compared only on edges surely honoured
`timescale 1ns/100ps
module tb_top;
   logic clk = 0, reset_n = 0, clk_en = 1, output_enable_n = 0, sleep_want = 0, ok = 0, was = 0;
   logic [1:0] op = 2'h0;
   logic [3:0] exp;
   logic rp = 0, de = 0, sq = 0;
   logic [1:0] rh = 2'h0;
   logic chip_select1_n, chip_select2, chip_select3_n, address_advance, write_enable_n;
   logic sleep_request, read_start, write_start, burst_continue, deselect, selected;
   logic in_sleep, inputs_enabled, data_out_en, sleep_state_entered;
   int seed = 32'h3596, error_cnt = 0, tests_run = 0;
   initial forever #5 clk = ~clk;
   host_model host (.*);
   sleep_ctl dut (.*);
   // expected {read, write, continue, deselect} from the pins
   function automatic logic [3:0] kind(input logic p);
      if (address_advance) return {2'b00, p, 1'b0};
      if (chip_select1_n) return 4'h1;
      return {write_enable_n, !write_enable_n, 2'b00};
   endfunction
   task automatic chk(input logic [3:0] s, input logic [3:0] w);
      tests_run++;
      if (s !== w) begin
         error_cnt++;
         $display("wrong value at %0t: %h not %h", $time, s, w);
      end
   endtask
   task automatic run(input int n, input logic rnd, input logic [1:0] o);
      for (int k = 0; k < n; k++) begin
         @(posedge clk);
         #1;
         if (ok) chk({read_start, write_start, burst_continue, deselect}, exp);
         if (clk_en) begin
            was = ok && (address_advance ? was : exp[3] | exp[2]);
            rp = ok && (address_advance ? rp : exp[3]);
            de = rp && !output_enable_n && !rh[1];
            rh = {rh[0], sq};
         end
         chk({2'b00, selected, data_out_en}, {2'b00, was, de});
         op = rnd ? 2'($random(seed)) : o;
         if (rnd) clk_en = 3'($random(seed)) != 3'h0;
         if (rnd) output_enable_n = 1'($random(seed));
         #1;
         ok = clk_en && inputs_enabled;
         sq = sleep_request;
         exp = kind(was);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      #1;
      reset_n = 1;
      ok = 1;
      exp = kind(1'b0);
      // back-to-back kinds, burst after read
      for (int i = 0; i < 9; i++) run(1, 0, 2'(i ^ (i >> 1)));
      $display("done: kinds");
      sleep_want = 1;
      run(3, 0, 2'h0);
      run(10, 0, 2'h1);
      chk({in_sleep, inputs_enabled, data_out_en, read_start}, 4'h8);
      sleep_want = 0;
      run(3, 0, 2'h1);
      chk({2'b00, inputs_enabled, read_start}, 4'h0);
      run(6, 0, 2'h1);
      chk({in_sleep, inputs_enabled, 2'b00}, 4'h4);
      $display("done: sleep");
      repeat (25) begin
         sleep_want = 1'($random(seed));
         run(40, 1, 2'h0);
      end
      $display("done: random");
      conclude();
   end
endmodule
bind sleep_ctl sleep_ctl_assertions #(.ENTRY_CYCLES(ENTRY_CYCLES), .EXIT_CYCLES(EXIT_CYCLES)) mon (.*);
